// *** include/uraf_params.svh ***
// register offsets, field positions, reset values and timing counts of the receiver
`ifndef URAF_PARAMS_SVH
`define URAF_PARAMS_SVH

`define URAF_ADDR_RXBUF 3'h0
`define URAF_ADDR_DIV_LO 3'h1
`define URAF_ADDR_DIV_HI 3'h2
`define URAF_ADDR_LINE_CTRL 3'h3
`define URAF_ADDR_MODEM_CTRL 3'h4
`define URAF_ADDR_LINE_STAT 3'h5
`define URAF_ADDR_FIFO_CTRL 3'h6
`define URAF_ADDR_MODEM_STAT 3'h7

`define URAF_LC_PAR_EN 3
`define URAF_LC_PAR_EVEN 4
`define URAF_MC_RTS 1
`define URAF_MC_AUTOFLOW 5
`define URAF_FC_ENABLE 0
`define URAF_FC_RX_CLEAR 1

`define URAF_DIV_RESET 16'h0001
`define URAF_FIFO_DEPTH 5'h10
`define URAF_TICK_MID 4'h7
`define URAF_TICK_LAST 4'hF
`define URAF_TRIG_1 5'h01
`define URAF_TRIG_4 5'h04
`define URAF_TRIG_8 5'h08
`define URAF_TRIG_14_HOLD 5'h0F

`endif

// *** include/uraf_pkg.sv ***
// types of the receiver with automatic flow control
package uraf_pkg;

  typedef enum logic [2:0]
  {
    URAF_IDLE = 3'h0,
    URAF_START = 3'h1,
    URAF_DATA = 3'h3,
    URAF_PARITY = 3'h2,
    URAF_STOP = 3'h6
  } uraf_rx_state_e;

  typedef struct packed
  {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } uraf_entry_s;

  typedef struct packed
  {
    logic [15:0][10:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] fifo_ctrl;
    logic [2:0] rx_sync;
    logic rx_lvl;
    logic [2:0] cts_sync;
    logic cts_lvl;
    logic delta_cts;
    logic overrun_error_flag;
    uraf_rx_state_e st;
    logic [3:0] scnt;
    logic [2:0] bitcnt;
    logic [7:0] receive_shift_reg;
    logic par_bit;
    logic rts_n;
    logic [7:0] rdata;
  } uraf_state_s;

endpackage : uraf_pkg

// *** rtl/uraf_receiver.sv ***
// serial receive path, receive fifo, line status and automatic rts/cts flow control
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "uraf_params.svh"

// What this block does
// RQ1: divisor 1 at 16 MHz gives 1 Mbaud
// RQ2: 8 MHz: divisor 52 9600, 1 500000
// RQ3: idle watches for falling edge, then samples
// RQ4: start valid only if low mid-bit
// RQ5: two low line-control bits choose length
// RQ6: line-control bits 3,4 set parity
// RQ7: full character sets data-ready flag
// RQ8: reading the last buffered character clears data ready
// RQ9: unread character overwritten sets overrun
// RQ10: parity mismatch sets parity error
// RQ11: missing stop bit sets framing error
// RQ12: fifo stores character with error bits
// RQ13: start detected within one sample tick
// RQ14: auto-cts: start byte only while cts
// RQ15: remote drops cts before last stop
// RQ16: no auto-cts: send regardless of cts
// RQ17: auto-rts drops at trigger 1,4,8
// RQ18: one more byte still accepted
// RQ19: rts returns when fifo emptied
// RQ20: trigger 14: drop at sixteenth character
// RQ21: trigger 14: return when space free
// RQ22: autoflow hides cts change interrupts
// RQ23: autoflow full when flow and rts set
// RQ24: cts-only: flow set, rts bit clear
// RQ25: baud tick is clock over divisor
// RQ26: divisor write reloads baud counter
// RQ27: shown errors belong to fifo head
module uraf_receiver
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_serial_in_line,
  input wire logic i_cts_n,
  output logic o_rts_n,
  input wire logic i_tx_pending,
  input wire logic i_tx_ready,
  output logic o_tx_start,
  output logic o_modem_int,
  output logic o_rx_data_ready_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = `URAF_TRIG_1;
      2'h1: trig_level = `URAF_TRIG_4;
      2'h2: trig_level = `URAF_TRIG_8;
      default: trig_level = `URAF_TRIG_14_HOLD;
    endcase
  endfunction : trig_level

  function automatic logic settled_low(input logic [2:0] s);
    settled_low = (s[1] == s[2]) && !s[2];
  endfunction : settled_low

  uraf_pkg::uraf_state_s r;
  uraf_pkg::uraf_state_s next_r;
  uraf_pkg::uraf_entry_s head;
  uraf_pkg::uraf_entry_s new_entry;
  logic tick;
  logic wr_div;
  logic fall;
  logic push;
  logic pop;
  logic full;
  logic fifo_on;
  logic autoflow_enable_bit;
  logic full_auto;
  logic cts_active;
  logic rx_now;
  logic [2:0] last_bit;
  logic cts_edge;

  assign head = uraf_pkg::uraf_entry_s'(r.mem[r.rp]);
  assign fifo_on = r.fifo_ctrl[`URAF_FC_ENABLE];
  assign autoflow_enable_bit = r.modem_control_reg[`URAF_MC_AUTOFLOW];
  assign full_auto = autoflow_enable_bit && r.modem_control_reg[`URAF_MC_RTS]; // RQ23
  assign cts_active = !r.cts_lvl;
  assign rx_now = r.rx_lvl;
  assign last_bit = {1'b1, r.line_control_reg[1:0]}; // RQ5
  assign wr_div = i_wr && (i_addr == `URAF_ADDR_DIV_LO || i_addr == `URAF_ADDR_DIV_HI);
  assign tick = (r.bcnt <= 16'h0001) && !wr_div; // RQ25 RQ1 RQ2
  assign fall = r.rx_lvl && settled_low(r.rx_sync); // RQ13
  assign cts_edge = (r.cts_sync[1] == r.cts_sync[2]) && (r.cts_sync[2] != r.cts_lvl)
    && !autoflow_enable_bit; // RQ22
  assign pop = i_rd && (i_addr == `URAF_ADDR_RXBUF) && (r.cnt != 5'h00);
  assign full = fifo_on ? (r.cnt == `URAF_FIFO_DEPTH) : (r.cnt == 5'h01);
  assign push = tick && (r.st == uraf_pkg::URAF_STOP) && (r.scnt == `URAF_TICK_LAST);

  // ----------------------------------------------------------------
  // transmitter gate
  // ----------------------------------------------------------------
  assign o_tx_start = i_tx_pending && i_tx_ready && (!autoflow_enable_bit || cts_active); // RQ14 RQ16 RQ24
  assign o_rts_n = r.rts_n;
  assign o_rdata = r.rdata;
  assign o_modem_int = r.delta_cts;
  assign o_rx_data_ready_flag = (r.cnt != 5'h00);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    new_entry = '0;
    new_entry.data = r.receive_shift_reg;
    new_entry.pe = r.line_control_reg[`URAF_LC_PAR_EN]
      && ((^r.receive_shift_reg ^ r.par_bit) != !r.line_control_reg[`URAF_LC_PAR_EVEN]); // RQ10 RQ6
    new_entry.fe = !rx_now; // RQ11
    new_entry.brk = !rx_now && (r.receive_shift_reg == 8'h00) && !r.par_bit;
    // baud counter
    if (wr_div)
    begin
      next_r.bcnt = (i_addr == `URAF_ADDR_DIV_LO) ? {r.div[15:8], i_wdata}
        : {i_wdata, r.div[7:0]}; // RQ26
    end
    else if (tick)
    begin
      next_r.bcnt = r.div;
    end
    else
    begin
      next_r.bcnt = r.bcnt - 16'h0001;
    end
    // input synchronisers
    next_r.rx_sync = {r.rx_sync[1:0], i_serial_in_line};
    if (r.rx_sync[1] == r.rx_sync[2])
    begin
      next_r.rx_lvl = r.rx_sync[2];
    end
    next_r.cts_sync = {r.cts_sync[1:0], i_cts_n};
    if (r.cts_sync[1] == r.cts_sync[2])
    begin
      next_r.cts_lvl = r.cts_sync[2];
      if (r.cts_sync[2] != r.cts_lvl && !autoflow_enable_bit)
      begin
        next_r.delta_cts = 1'b1; // RQ22
      end
    end
    // register writes
    if (i_wr)
    begin
      unique case (i_addr)
        `URAF_ADDR_DIV_LO: next_r.div[7:0] = i_wdata;
        `URAF_ADDR_DIV_HI: next_r.div[15:8] = i_wdata;
        `URAF_ADDR_LINE_CTRL: next_r.line_control_reg = i_wdata;
        `URAF_ADDR_MODEM_CTRL: next_r.modem_control_reg = i_wdata;
        `URAF_ADDR_FIFO_CTRL: next_r.fifo_ctrl = i_wdata;
        default: next_r.div = r.div;
      endcase
    end
    // register reads, clears lose to a same-cycle set below
    next_r.rdata = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        `URAF_ADDR_RXBUF: next_r.rdata = head.data;
        `URAF_ADDR_DIV_LO: next_r.rdata = r.div[7:0];
        `URAF_ADDR_DIV_HI: next_r.rdata = r.div[15:8];
        `URAF_ADDR_LINE_CTRL: next_r.rdata = r.line_control_reg;
        `URAF_ADDR_MODEM_CTRL: next_r.rdata = r.modem_control_reg;
        `URAF_ADDR_LINE_STAT:
        begin
          next_r.rdata = {3'h0, head.brk && (r.cnt != 5'h00), head.fe && (r.cnt != 5'h00),
            head.pe && (r.cnt != 5'h00), r.overrun_error_flag, r.cnt != 5'h00}; // RQ27 RQ7
          next_r.overrun_error_flag = 1'b0;
        end
        `URAF_ADDR_FIFO_CTRL: next_r.rdata = r.fifo_ctrl;
        default:
        begin
          next_r.rdata = {3'h0, cts_active, 3'h0, r.delta_cts};
          next_r.delta_cts = cts_edge;
        end
      endcase
    end
    // receive sequencer
    if (tick)
    begin
      next_r.scnt = r.scnt + 4'h1;
    end
    unique case (r.st)
      uraf_pkg::URAF_IDLE:
      begin
        if (fall)
        begin
          next_r.st = uraf_pkg::URAF_START; // RQ3 RQ13
          next_r.scnt = 4'h0;
          next_r.bitcnt = 3'h0;
          next_r.receive_shift_reg = 8'h00;
          next_r.par_bit = 1'b0;
        end
      end
      uraf_pkg::URAF_START:
      begin
        if (tick && r.scnt == `URAF_TICK_MID)
        begin
          next_r.scnt = 4'h0;
          next_r.st = rx_now ? uraf_pkg::URAF_IDLE : uraf_pkg::URAF_DATA; // RQ4
        end
      end
      uraf_pkg::URAF_DATA:
      begin
        if (tick && r.scnt == `URAF_TICK_LAST)
        begin
          next_r.receive_shift_reg[r.bitcnt] = rx_now;
          next_r.bitcnt = r.bitcnt + 3'h1;
          if (r.bitcnt == last_bit)
          begin
            next_r.st = r.line_control_reg[`URAF_LC_PAR_EN] ? uraf_pkg::URAF_PARITY
              : uraf_pkg::URAF_STOP; // RQ5 RQ6
          end
        end
      end
      uraf_pkg::URAF_PARITY:
      begin
        if (tick && r.scnt == `URAF_TICK_LAST)
        begin
          next_r.par_bit = rx_now;
          next_r.st = uraf_pkg::URAF_STOP;
        end
      end
      uraf_pkg::URAF_STOP:
      begin
        if (push)
        begin
          next_r.st = uraf_pkg::URAF_IDLE;
        end
      end
      default: next_r.st = uraf_pkg::URAF_IDLE;
    endcase
    // receive fifo
    if (pop)
    begin
      next_r.rp = r.rp + 4'h1; // RQ8
      next_r.cnt = r.cnt - 5'h01;
    end
    if (push)
    begin
      if (!full || pop)
      begin
        next_r.mem[r.wp] = new_entry; // RQ12
        next_r.wp = r.wp + 4'h1;
        next_r.cnt = next_r.cnt + 5'h01; // RQ7 RQ18
      end
      else
      begin
        next_r.overrun_error_flag = 1'b1; // RQ9
        if (!fifo_on)
        begin
          next_r.mem[r.rp] = new_entry;
        end
      end
    end
    if (i_wr && i_addr == `URAF_ADDR_FIFO_CTRL && i_wdata[`URAF_FC_RX_CLEAR])
    begin
      next_r.cnt = 5'h00;
      next_r.wp = 4'h0;
      next_r.rp = 4'h0;
    end
    // request to send
    if (!full_auto)
    begin
      next_r.rts_n = !r.modem_control_reg[`URAF_MC_RTS];
    end
    else if (r.fifo_ctrl[7:6] == 2'h3)
    begin
      next_r.rts_n = (r.cnt == `URAF_FIFO_DEPTH)
        || (r.cnt == `URAF_TRIG_14_HOLD && r.st == uraf_pkg::URAF_DATA); // RQ20 RQ21
    end
    else if (r.cnt >= trig_level(r.fifo_ctrl[7:6]))
    begin
      next_r.rts_n = 1'b1; // RQ17
    end
    else if (r.cnt == 5'h00)
    begin
      next_r.rts_n = 1'b0; // RQ19
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '{mem: '0, wp: 4'h0, rp: 4'h0, cnt: 5'h00, div: `URAF_DIV_RESET,
        bcnt: `URAF_DIV_RESET, line_control_reg: 8'h00, modem_control_reg: 8'h00,
        fifo_ctrl: 8'h00, rx_sync: 3'h7, rx_lvl: 1'b1, cts_sync: 3'h7, cts_lvl: 1'b1,
        delta_cts: 1'b0, overrun_error_flag: 1'b0, st: uraf_pkg::URAF_IDLE, scnt: 4'h0,
        bitcnt: 3'h0, receive_shift_reg: 8'h00, par_bit: 1'b0, rts_n: 1'b1, rdata: 8'h00};
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  property p_div_reload;
    (i_wr && i_addr == `URAF_ADDR_DIV_LO) |=> (r.bcnt == r.div) && (r.div[7:0] == $past(i_wdata));
  endproperty
  a_div_reload: assert property (p_div_reload) else $error("divisor write did not reload"); // RQ26

  property p_tick_period;
    (tick && r.div == 16'h0002 && !wr_div) ##1 !wr_div |-> !tick ##1 (wr_div || tick);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("baud tick period wrong"); // RQ25

  property p_start_edge;
    (r.st == uraf_pkg::URAF_IDLE && fall) |=> r.st == uraf_pkg::URAF_START && r.scnt == 4'h0;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("falling edge not taken"); // RQ3

  property p_false_start;
    (r.st == uraf_pkg::URAF_START && tick && r.scnt == `URAF_TICK_MID && rx_now)
      |=> r.st == uraf_pkg::URAF_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("noise accepted as start"); // RQ4

  property p_data_ready;
    (push && !full) |=> o_rx_data_ready_flag;
  endproperty
  a_data_ready: assert property (p_data_ready) else $error("data ready not set"); // RQ7

  property p_overrun;
    (push && full && !pop) |=> r.overrun_error_flag && r.cnt == $past(r.cnt);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RQ9

  property p_rts_drop;
    (full_auto && r.fifo_ctrl[7:6] != 2'h3 && r.cnt >= trig_level(r.fifo_ctrl[7:6]))
      |=> o_rts_n;
  endproperty
  a_rts_drop: assert property (p_rts_drop) else $error("rts held at trigger"); // RQ17

  property p_rts_return;
    (full_auto && r.fifo_ctrl[7:6] != 2'h3 && r.cnt == 5'h00) |=> !o_rts_n;
  endproperty
  a_rts_return: assert property (p_rts_return) else $error("rts not returned"); // RQ19

  property p_rts_space14;
    (full_auto && r.fifo_ctrl[7:6] == 2'h3 && r.cnt < `URAF_TRIG_14_HOLD) |=> !o_rts_n;
  endproperty
  a_rts_space14: assert property (p_rts_space14) else $error("rts held with space"); // RQ21

  property p_cts_gate;
    (autoflow_enable_bit && !cts_active) |-> !o_tx_start;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("byte started without cts"); // RQ14

  property p_no_cts_int;
    (autoflow_enable_bit && !r.delta_cts && !(i_wr && i_addr == `URAF_ADDR_MODEM_CTRL))
      |=> !r.delta_cts;
  endproperty
  a_no_cts_int: assert property (p_no_cts_int) else $error("cts change raised event"); // RQ22

  c_false_start: cover property (r.st == uraf_pkg::URAF_START ##1 r.st == uraf_pkg::URAF_IDLE);
  c_char_stored: cover property (push && !full);
  c_rts_drop: cover property (full_auto && !o_rts_n ##1 o_rts_n);
  c_tx_gated: cover property (i_tx_pending && i_tx_ready && !o_tx_start);

endmodule : uraf_receiver

// *** test/tb.sv ***
// self-checking bench of the receiver with automatic flow control
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, wr, rd, ser, cts_n, rts_n, tx_pend, tx_rdy, tx_start, mint, dr;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int n_errors = 0;
  int checked = 0;

  uraf_receiver u_uraf_receiver
  (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_serial_in_line(ser), .i_cts_n(cts_n),
    .o_rts_n(rts_n), .i_tx_pending(tx_pend), .i_tx_ready(tx_rdy),
    .o_tx_start(tx_start), .o_modem_int(mint), .o_rx_data_ready_flag(dr)
  );

  uraf_remote u_uraf_remote
  (
    .i_clk_sys(clk), .o_serial(ser), .o_cts_n(cts_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chb(input string nm, input logic e, ref logic g);
    @(negedge clk);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask : chb

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rexp(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
  endtask : rexp

  task automatic tx(input logic [7:0] d, input int nb = 8);
    u_uraf_remote.send(d, nb, 1'b0, 1'b0, 1'b1);
  endtask : tx

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chb("rts_n", 1'b1, rts_n);
    chb("ready", 1'b0, dr);
    chb("modem_int", 1'b0, mint);
    rexp("line_status", 3'h5, 8'h00);
  endtask : t_reset

  task automatic t_length();
    wreg(3'h6, 8'h01);
    for (int l = 5; l <= 8; l++)
    begin
      wreg(3'h3, 8'(l - 5));
      tx(8'hA5, l);
      chb("ready", 1'b1, dr);
      rexp("line_status", 3'h5, 8'h01);
      rexp("rx_data", 3'h0, 8'hA5 & (8'hFF >> (8 - l)));
      chb("ready", 1'b0, dr);
    end
  endtask : t_length

  task automatic t_parity();
    logic pb;
    for (int m = 0; m < 2; m++)
    begin
      wreg(3'h3, m ? 8'h1B : 8'h0B);
      pb = (m == 0);
      u_uraf_remote.send(8'h03, 8, 1'b1, ~pb, 1'b1);
      u_uraf_remote.send(8'h03, 8, 1'b1, pb, 1'b1);
      rexp("line_status", 3'h5, 8'h05);
      rexp("rx_data", 3'h0, 8'h03);
      rexp("line_status", 3'h5, 8'h01);
      rexp("rx_data", 3'h0, 8'h03);
    end
  endtask : t_parity

  task automatic t_frame_noise();
    wreg(3'h3, 8'h03);
    u_uraf_remote.send(8'hA5, 8, 1'b0, 1'b0, 1'b0);
    rexp("line_status", 3'h5, 8'h09);
    rexp("rx_data", 3'h0, 8'hA5);
    u_uraf_remote.send(8'h00, 8, 1'b0, 1'b0, 1'b0);
    rexp("line_status", 3'h5, 8'h19);
    rexp("rx_data", 3'h0, 8'h00);
    u_uraf_remote.glitch(5);
    repeat (300) @(posedge clk);
    chb("ready", 1'b0, dr);
    tx(8'h3C);
    rexp("rx_data", 3'h0, 8'h3C);
  endtask : t_frame_noise

  task automatic t_divisor();
    wreg(3'h1, 8'h02);
    wreg(3'h2, 8'h00);
    u_uraf_remote.div = 2;
    tx(8'h5A);
    rexp("rx_data", 3'h0, 8'h5A);
    wreg(3'h1, 8'h01);
    u_uraf_remote.div = 1;
  endtask : t_divisor

  task automatic t_overrun();
    wreg(3'h6, 8'h02);
    tx(8'h11);
    tx(8'h22);
    rexp("line_status", 3'h5, 8'h03);
    rexp("rx_data", 3'h0, 8'h22);
    chb("ready", 1'b0, dr);
    rexp("line_status", 3'h5, 8'h00);
  endtask : t_overrun

  task automatic t_autorts();
    int tl;
    wreg(3'h4, 8'h22);
    for (int k = 0; k < 3; k++)
    begin
      tl = (k == 0) ? 1 : 4 * k;
      wreg(3'h6, {k[1:0], 6'h03});
      for (int i = 0; i < tl; i++)
      begin
        chb("rts_n", 1'b0, rts_n);
        tx(8'(i));
      end
      chb("rts_n", 1'b1, rts_n);
      tx(8'hEE);
      for (int i = 0; i < tl; i++)
      begin
        rexp("rx_data", 3'h0, 8'(i));
        chb("rts_n", 1'b1, rts_n);
      end
      rexp("rx_data", 3'h0, 8'hEE);
      repeat (2) @(negedge clk);
      chb("rts_n", 1'b0, rts_n);
    end
  endtask : t_autorts

  task automatic t_trig14();
    wreg(3'h6, 8'hC3);
    for (int i = 0; i < 15; i++)
      tx(8'(i));
    fork
      tx(8'h0F);
      begin
        repeat (8) @(negedge clk);
        chb("rts_n", 1'b0, rts_n);
        repeat (40) @(negedge clk);
        chb("rts_n", 1'b1, rts_n);
      end
    join
    rexp("rx_data", 3'h0, 8'h00);
    repeat (2) @(negedge clk);
    chb("rts_n", 1'b0, rts_n);
  endtask : t_trig14

  task automatic t_autocts();
    @(posedge clk);
    tx_pend <= 1'b1;
    tx_rdy <= 1'b1;
    wreg(3'h4, 8'h00);
    chb("tx_start", 1'b1, tx_start);
    wreg(3'h4, 8'h20);
    chb("tx_start", 1'b0, tx_start);
    chb("rts_n", 1'b1, rts_n);
    u_uraf_remote.set_cts(1'b0);
    repeat (6) @(negedge clk);
    chb("tx_start", 1'b1, tx_start);
    chb("modem_int", 1'b0, mint);
    @(posedge clk);
    tx_rdy <= 1'b0;
    chb("tx_start", 1'b0, tx_start);
    wreg(3'h4, 8'h00);
    u_uraf_remote.set_cts(1'b1);
    repeat (6) @(negedge clk);
    chb("modem_int", 1'b1, mint);
    rexp("modem_status", 3'h7, 8'h01);
    chb("modem_int", 1'b0, mint);
  endtask : t_autocts

  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    tx_pend = 1'b0;
    tx_rdy = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_length();
    t_parity();
    t_frame_noise();
    t_divisor();
    t_overrun();
    t_autorts();
    t_trig14();
    t_autocts();
    report_and_stop();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : tb

// *** test/uraf_remote.sv ***
// remote serial sender and clear-to-send source
`timescale 1ns/1ps
module uraf_remote
(
  input wire logic i_clk_sys,
  output logic o_serial,
  output logic o_cts_n
);
  // ----------------------------------------
  // line driver
  // ----------------------------------------
  int div = 1;

  initial
  begin
    o_serial = 1'b1;
    o_cts_n = 1'b1;
  end

  task automatic bit_wait();
    repeat (16 * div) @(posedge i_clk_sys);
  endtask : bit_wait

  // one frame, lsb first, optional parity bit, chosen stop level
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic pb,
    input logic stp);
    @(posedge i_clk_sys);
    o_serial <= 1'b0;
    bit_wait();
    for (int i = 0; i < nb; i++)
    begin
      o_serial <= d[i];
      bit_wait();
    end
    if (pen)
    begin
      o_serial <= pb;
      bit_wait();
    end
    o_serial <= stp;
    bit_wait();
    o_serial <= 1'b1;
    bit_wait();
  endtask : send

  // low spike shorter than half a bit
  task automatic glitch(input int n);
    @(posedge i_clk_sys);
    o_serial <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
    o_serial <= 1'b1;
  endtask : glitch

  // cts changes only between frames, well before the last stop bit
  task automatic set_cts(input logic v);
    @(posedge i_clk_sys);
    o_cts_n <= v;
  endtask : set_cts
endmodule : uraf_remote
